// *** core/ctm_pkg.sv ***
// Package for the 16-bit capture timer: register offsets, field positions, reset values and enumerations.
// Assumes a byte-wide register port and one 40 MHz system clock.
package ctm_pkg;

  // Register offsets.
  localparam logic [3:0] CTM_OFS_CTRL_MAIN  = 4'h0;
  localparam logic [3:0] CTM_OFS_CTRL_MODE  = 4'h1;
  localparam logic [3:0] CTM_OFS_EVT_CTRL   = 4'h4;
  localparam logic [3:0] CTM_OFS_INT_EN     = 4'h5;
  localparam logic [3:0] CTM_OFS_INT_FLAG   = 4'h6;
  localparam logic [3:0] CTM_OFS_RUN_STATE  = 4'h7;
  localparam logic [3:0] CTM_OFS_HALT_CTRL  = 4'h8;
  localparam logic [3:0] CTM_OFS_WIDE_LATCH = 4'h9;
  localparam logic [3:0] CTM_OFS_CNT_LO     = 4'ha;
  localparam logic [3:0] CTM_OFS_CNT_HI     = 4'hb;
  localparam logic [3:0] CTM_OFS_CCV_LO     = 4'hc;
  localparam logic [3:0] CTM_OFS_CCV_HI     = 4'hd;

  // Field positions.
  localparam int CTM_BIT_ENABLE     = 0;
  localparam int CTM_BIT_CLOCK_SOURCE_SELECT_LO  = 1;
  localparam int CTM_BIT_FOLLOW     = 4;
  localparam int CTM_BIT_RUNSTBY    = 6;
  localparam int CTM_BIT_MODE_LO    = 0;
  localparam int CTM_BIT_OUT_EN     = 4;
  localparam int CTM_BIT_OUT_INIT   = 5;
  localparam int CTM_BIT_EARLY_RISE = 6;
  localparam int CTM_BIT_EVT_EN     = 0;
  localparam int CTM_BIT_EDGE       = 4;
  localparam int CTM_BIT_FILTER     = 6;

  // Writable masks, which double as the read-back masks of reserved bits.
  localparam logic [7:0] CTM_MASK_CTRL_MAIN = 8'h57;
  localparam logic [7:0] CTM_MASK_CTRL_MODE = 8'h77;
  localparam logic [7:0] CTM_MASK_EVT_CTRL  = 8'h51;
  localparam logic [7:0] CTM_MASK_BIT0      = 8'h01;

  // Reset values.
  localparam logic [7:0]  CTM_RST_BYTE = 8'h00;
  localparam logic [15:0] CTM_RST_WORD = 16'h0000;

  // Noise filter length in samples.
  localparam int CTM_FILTER_LEN = 4;

  typedef enum logic [2:0] {
    CTM_MODE_PERIODIC = 3'b000,
    CTM_MODE_TIMEOUT  = 3'b001,
    CTM_MODE_CAPTURE  = 3'b010,
    CTM_MODE_FREQ     = 3'b011,
    CTM_MODE_PWIDTH   = 3'b100,
    CTM_MODE_FREQPW   = 3'b101,
    CTM_MODE_SHOT     = 3'b110,
    CTM_MODE_PWM8     = 3'b111
  } ctm_mode_t;

  typedef enum logic [1:0] {
    CTM_PERIPHERAL_CLOCK  = 2'b00,
    CTM_CLK_DIV2 = 2'b01,
    CTM_CLK_COMP = 2'b10,
    CTM_CLK_RSVD = 2'b11
  } ctm_clock_source_select_t;

  typedef enum logic [1:0] {
    CTM_FP_IDLE = 2'b00,
    CTM_FP_HIGH = 2'b01,
    CTM_FP_LOW  = 2'b10
  } ctm_fpw_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctm_req_t;

  // Power and companion inputs, all synchronous to clk_sys.
  typedef struct packed {
    logic sleep_power_down;
    logic sleep_standby;
    logic debug_halt;
    logic comp_tick;
    logic comp_restart;
  } ctm_sys_t;

endpackage

// *** core/ctm_timer.sv ***
// Sixteen-bit capture timer core with a byte-wide register port and one event input.
// Assumes the companion tick and restart and the sleep levels are synchronous to clk_sys;
// the event line comes from routing logic outside this domain and is synchronised here.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ctm_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire ctm_pkg::ctm_req_t req,
  input  wire ctm_pkg::ctm_sys_t sys,
  input  wire logic              event_in,
  output logic [7:0]             rdata,
  output logic                   compare_out,
  output logic                   capture_irq
);
  import ctm_pkg::*;

  // Register state.
  logic [7:0]       ctrl_main_r, ctrl_mode_r, evt_ctrl_r, int_en_r, halt_ctrl_r, wide_latch_r;
  logic             flag_r, run_r, out_r, div_r, edge_seen_r, pwm_lvl_r;
  logic [CNT_W-1:0] cnt_r, ccv_r, cnt_nxt, ccv_nxt;
  logic             flag_nxt, run_nxt, out_nxt, edge_seen_nxt;
  ctm_fpw_t         fpw_r, fpw_nxt;
  logic [1:0]       evt_sync_r;
  logic [CTM_FILTER_LEN-1:0] hist_r;
  logic             evt_filt_r, evt_prev_r;

  // Field decode.
  wire ctm_mode_t   mode      = ctm_mode_t'(ctrl_mode_r[CTM_BIT_MODE_LO +: 3]);
  wire ctm_clock_source_select_t clock_source_select    = ctm_clock_source_select_t'(ctrl_main_r[CTM_BIT_CLOCK_SOURCE_SELECT_LO +: 2]);
  wire              enable    = ctrl_main_r[CTM_BIT_ENABLE];
  wire              run_stby  = ctrl_main_r[CTM_BIT_RUNSTBY];
  wire              follow    = ctrl_main_r[CTM_BIT_FOLLOW];
  wire              early     = ctrl_mode_r[CTM_BIT_EARLY_RISE];
  wire              out_init  = ctrl_mode_r[CTM_BIT_OUT_INIT];
  wire              out_en    = ctrl_mode_r[CTM_BIT_OUT_EN];
  wire              evt_en    = evt_ctrl_r[CTM_BIT_EVT_EN];
  wire              edge_sel  = evt_ctrl_r[CTM_BIT_EDGE];
  wire              filt_en   = evt_ctrl_r[CTM_BIT_FILTER];

  // The block is active only while enabled and not held by a sleep state or a debug halt.
  wire sleeping = sys.sleep_power_down | (sys.sleep_standby & ~run_stby);
  wire halted   = sys.debug_halt & ~halt_ctrl_r[0];
  wire active   = enable & ~sleeping & ~halted;

  // Count tick; the reserved select never ticks.
  wire tick = active & ((clock_source_select == CTM_PERIPHERAL_CLOCK) | ((clock_source_select == CTM_CLK_DIV2) & div_r) |
                        ((clock_source_select == CTM_CLK_COMP) & sys.comp_tick));

  // Event path: the filtered level only moves when the full history agrees.
  wire hist_equal = (hist_r == {CTM_FILTER_LEN{1'b1}}) | (hist_r == {CTM_FILTER_LEN{1'b0}});
  wire evt_level  = filt_en ? evt_filt_r : evt_sync_r[1];
  wire rise_raw   = evt_level & ~evt_prev_r;
  wire fall_raw   = ~evt_level & evt_prev_r;
  wire evt_ok     = evt_en & active;
  wire sel_edge   = evt_ok & (edge_sel ? fall_raw : rise_raw);
  wire opp_edge   = evt_ok & (edge_sel ? rise_raw : fall_raw);
  wire any_edge   = evt_ok & (rise_raw | fall_raw);

  // Register port decode.
  wire wr_main  = req.wr & (req.addr == CTM_OFS_CTRL_MAIN);
  wire wr_mode  = req.wr & (req.addr == CTM_OFS_CTRL_MODE);
  wire wr_evt   = req.wr & (req.addr == CTM_OFS_EVT_CTRL);
  wire wr_inten = req.wr & (req.addr == CTM_OFS_INT_EN);
  wire wr_flag  = req.wr & (req.addr == CTM_OFS_INT_FLAG) & req.wdata[0];
  wire wr_halt  = req.wr & (req.addr == CTM_OFS_HALT_CTRL);
  wire wr_latch = req.wr & (req.addr == CTM_OFS_WIDE_LATCH);
  wire wr_cnt_l = req.wr & (req.addr == CTM_OFS_CNT_LO);
  wire wr_cnt_h = req.wr & (req.addr == CTM_OFS_CNT_HI);
  wire wr_ccv_l = req.wr & (req.addr == CTM_OFS_CCV_LO);
  wire wr_ccv_h = req.wr & (req.addr == CTM_OFS_CCV_HI);
  wire rd_ccv   = req.rd & ((req.addr == CTM_OFS_CCV_LO) | (req.addr == CTM_OFS_CCV_HI));

  wire capture_mode = (mode == CTM_MODE_CAPTURE) | (mode == CTM_MODE_FREQ) |
                      (mode == CTM_MODE_PWIDTH) | (mode == CTM_MODE_FREQPW);
  wire at_top       = (cnt_r == ccv_r);

  // Read multiplexer; reserved bits and unmapped offsets return zero.
  function automatic logic [7:0] rd_mux(input logic [3:0] a);
    unique case (a)
      CTM_OFS_CTRL_MAIN:  rd_mux = ctrl_main_r & CTM_MASK_CTRL_MAIN;
      CTM_OFS_CTRL_MODE:  rd_mux = ctrl_mode_r & CTM_MASK_CTRL_MODE;
      CTM_OFS_EVT_CTRL:   rd_mux = evt_ctrl_r & CTM_MASK_EVT_CTRL;
      CTM_OFS_INT_EN:     rd_mux = int_en_r & CTM_MASK_BIT0;
      CTM_OFS_INT_FLAG:   rd_mux = {7'h00, flag_r};
      CTM_OFS_RUN_STATE:  rd_mux = {7'h00, run_r};
      CTM_OFS_HALT_CTRL:  rd_mux = halt_ctrl_r & CTM_MASK_BIT0;
      CTM_OFS_WIDE_LATCH: rd_mux = wide_latch_r;
      CTM_OFS_CNT_LO:     rd_mux = cnt_r[7:0];
      CTM_OFS_CNT_HI:     rd_mux = cnt_r[15:8];
      CTM_OFS_CCV_LO:     rd_mux = ccv_r[7:0];
      CTM_OFS_CCV_HI:     rd_mux = ccv_r[15:8];
      default:            rd_mux = 8'h00;
    endcase
  endfunction

  // Counting and event actions. Hardware sets of the flag take priority over software clears.
  always_comb begin
    cnt_nxt       = cnt_r;
    ccv_nxt       = ccv_r;
    run_nxt       = run_r;
    out_nxt       = out_r;
    edge_seen_nxt = edge_seen_r;
    fpw_nxt       = fpw_r;
    flag_nxt      = flag_r;
    if (wr_flag | (rd_ccv & capture_mode)) begin
      flag_nxt = 1'b0;
    end
    if (!enable) begin
      run_nxt       = 1'b0;
      fpw_nxt       = CTM_FP_IDLE;
      edge_seen_nxt = 1'b0; // A stale pending rise must not leak into the next shot.
      out_nxt = out_init;
    end else if (active) begin
      unique case (mode)
        CTM_MODE_PERIODIC: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = at_top ? '0 : cnt_r + 1'b1;
            if (at_top) flag_nxt = 1'b1;
          end
        end
        CTM_MODE_TIMEOUT: begin
          if (sel_edge) begin
            run_nxt = 1'b1;
            cnt_nxt = '0;
          end else if (opp_edge) begin
            run_nxt = 1'b0;
          end else if (run_r && tick) begin
            cnt_nxt = cnt_r + 1'b1;
            if (at_top) begin
              flag_nxt = 1'b1;
              run_nxt  = 1'b0;
            end
          end
        end
        CTM_MODE_CAPTURE: begin
          run_nxt = 1'b1;
          if (tick) cnt_nxt = cnt_r + 1'b1;
          if (sel_edge) begin
            ccv_nxt  = cnt_r;
            flag_nxt = 1'b1;
          end
        end
        CTM_MODE_FREQ: begin
          run_nxt = 1'b1;
          if (sel_edge) begin
            ccv_nxt  = cnt_r;
            cnt_nxt  = '0;
            flag_nxt = 1'b1;
          end else if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        CTM_MODE_PWIDTH: begin
          run_nxt = 1'b1;
          if (sel_edge) begin
            cnt_nxt = '0;
          end else if (opp_edge) begin
            ccv_nxt  = cnt_r;
            flag_nxt = 1'b1;
          end else if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
        CTM_MODE_FREQPW: begin
          if (run_r && tick) cnt_nxt = cnt_r + 1'b1;
          unique case (fpw_r)
            CTM_FP_IDLE: if (sel_edge) begin
              cnt_nxt = '0;
              run_nxt = 1'b1;
              fpw_nxt = CTM_FP_HIGH;
            end
            CTM_FP_HIGH: if (opp_edge) begin
              ccv_nxt = cnt_r;
              fpw_nxt = CTM_FP_LOW;
            end
            CTM_FP_LOW: if (sel_edge) begin
              run_nxt  = 1'b0;
              flag_nxt = 1'b1;
              fpw_nxt  = CTM_FP_IDLE;
            end
            default: fpw_nxt = CTM_FP_IDLE;
          endcase
        end
        CTM_MODE_SHOT: begin
          if (!run_r && (edge_sel ? any_edge : (evt_ok & rise_raw))) begin
            run_nxt = 1'b1;
            cnt_nxt = '0;
            if (early) out_nxt = 1'b1;
            else edge_seen_nxt = 1'b1;
          end else if (run_r && tick) begin
            if (edge_seen_r) begin
              out_nxt       = 1'b1;
              edge_seen_nxt = 1'b0;
            end
            cnt_nxt = cnt_r + 1'b1;
            if (at_top) begin
              run_nxt  = 1'b0;
              out_nxt  = 1'b0;
              flag_nxt = 1'b1;
            end
          end
        end
        CTM_MODE_PWM8: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = (cnt_r[7:0] >= ccv_r[7:0]) ? '0 : cnt_r + 1'b1;
            if (cnt_r[7:0] == ccv_r[15:8]) flag_nxt = 1'b1;
          end
          out_nxt = pwm_lvl_r;
        end
      endcase
      if (follow && sys.comp_restart) cnt_nxt = '0;
    end
    // Software writes to the counter take priority over internal updates.
    if (wr_cnt_l) cnt_nxt = {cnt_nxt[15:8], req.wdata};
    if (wr_cnt_h) cnt_nxt = {req.wdata, cnt_nxt[7:0]};
    if (wr_ccv_l) ccv_nxt = {ccv_nxt[15:8], req.wdata};
    if (wr_ccv_h) ccv_nxt = {req.wdata, ccv_nxt[7:0]};
  end

  // Event synchroniser, sample history and filtered level.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      evt_sync_r <= 2'b00;
      hist_r     <= '0;
      evt_filt_r <= 1'b0;
      evt_prev_r <= 1'b0;
    end else begin
      evt_sync_r <= {evt_sync_r[0], event_in};
      hist_r     <= {hist_r[CTM_FILTER_LEN-2:0], evt_sync_r[1]};
      if (hist_equal) evt_filt_r <= hist_r[0];
      evt_prev_r <= evt_level;
    end
  end

  // Configuration registers; only the writable bits are stored.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_main_r  <= CTM_RST_BYTE;
      ctrl_mode_r  <= CTM_RST_BYTE;
      evt_ctrl_r   <= CTM_RST_BYTE;
      int_en_r     <= CTM_RST_BYTE;
      halt_ctrl_r  <= CTM_RST_BYTE;
      wide_latch_r <= CTM_RST_BYTE;
    end else begin
      if (wr_main)  ctrl_main_r  <= req.wdata & CTM_MASK_CTRL_MAIN;
      if (wr_mode)  ctrl_mode_r  <= req.wdata & CTM_MASK_CTRL_MODE;
      if (wr_evt)   evt_ctrl_r   <= req.wdata & CTM_MASK_EVT_CTRL;
      if (wr_inten) int_en_r     <= req.wdata & CTM_MASK_BIT0;
      if (wr_halt)  halt_ctrl_r  <= req.wdata & CTM_MASK_BIT0;
      if (wr_latch) wide_latch_r <= req.wdata;
    end
  end

  // Timer state, half-rate divider and the PWM level.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r       <= CTM_RST_WORD;
      ccv_r       <= CTM_RST_WORD;
      flag_r      <= 1'b0;
      run_r       <= 1'b0;
      out_r       <= 1'b0;
      edge_seen_r <= 1'b0;
      fpw_r       <= CTM_FP_IDLE;
      div_r       <= 1'b0;
      pwm_lvl_r   <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt;
      ccv_r       <= ccv_nxt;
      flag_r      <= flag_nxt;
      run_r       <= run_nxt;
      out_r       <= out_nxt;
      edge_seen_r <= edge_seen_nxt;
      fpw_r       <= fpw_nxt;
      div_r       <= active ? ~div_r : 1'b0;
      pwm_lvl_r   <= (ccv_r[7:0] != 8'h00) && (cnt_nxt[7:0] < ccv_r[15:8]);
    end
  end

  // Outputs, all registered. Non-shot, non-PWM modes show the initial level.
  wire out_mode = ((mode == CTM_MODE_SHOT) | (mode == CTM_MODE_PWM8)) ? out_nxt : out_init;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata       <= 8'h00;
      compare_out <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      rdata       <= req.rd ? rd_mux(req.addr) : 8'h00;
      compare_out <= out_en & out_mode;
      capture_irq <= flag_nxt & int_en_r[0];
    end
  end

endmodule

// *** tb/ctm_partner.sv ***
// Far-side model: companion tick and restart pulses and the routed event line.
// Assumes one clock shared with the timer; the bench commands the event level.
`timescale 1ns/100ps
module ctm_partner #(
  parameter int TICK_DIV    = 4,
  parameter int RESTART_DIV = 32
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ev_cmd,
  output logic      comp_tick,
  output logic      comp_restart,
  output logic      event_out
);
  int div_r;
  // One divider feeds both pulses, so a restart always lands on a tick.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_r <= 0;
      event_out <= 1'b0;
    end else begin
      div_r <= div_r + 1;
      event_out <= ev_cmd;
    end
  end
  // Both pulses last one cycle, as the companion emits them.
  assign comp_tick    = (div_r % TICK_DIV) == TICK_DIV - 1;
  assign comp_restart = (div_r % RESTART_DIV) == RESTART_DIV - 1;
endmodule

// *** tb/ctm_timer_chk.sv ***
// Port-level assertions for the capture timer, bound to each instance.
// Assumes one-cycle strobes and read data in the cycle after a read.
`timescale 1ns/100ps
module ctm_timer_chk #(
  parameter int CNT_W = 16
) (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire ctm_pkg::ctm_req_t req,
  input wire ctm_pkg::ctm_sys_t sys,
  input wire logic              event_in,
  input wire logic [7:0]        rdata,
  input wire logic              compare_out,
  input wire logic              capture_irq
);
  import ctm_pkg::*;
  logic [7:0] main_r;
  logic [7:0] mode_r;
  logic       ie_r;
  logic [1:0] calm_r;
  logic [1:0] calm_nxt;
  logic       wr_main;
  logic       wr_mode;
  logic       wr_ie;
  // Output checks wait three quiet cycles, since the pin lags its state by one.
  assign wr_main  = req.wr && req.addr == 4'h0;
  assign wr_mode  = req.wr && req.addr == 4'h1;
  assign wr_ie    = req.wr && req.addr == 4'h5;
  assign calm_nxt = (wr_main || wr_mode) ? 2'h0 : ((calm_r == 2'h3) ? calm_r : calm_r + 2'h1);
  // Shadows keep only defined bits, so reserved bits must read as zero.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_r <= 8'h00;
      mode_r <= 8'h00;
      ie_r <= 1'b0;
      calm_r <= 2'h0;
    end else begin
      main_r <= wr_main ? (req.wdata & 8'h57) : main_r;
      mode_r <= wr_mode ? (req.wdata & 8'h77) : mode_r;
      ie_r <= wr_ie ? req.wdata[0] : ie_r;
      calm_r <= calm_nxt;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_rdata_idle : assert property (
    !req.rd |=> rdata == 8'h00) else $error("read data without a read");
  chk_hole_zero : assert property (
    req.rd && req.addr inside {4'h2, 4'h3, 4'he, 4'hf} |=> rdata == 8'h00) else $error("hole read nonzero");
  chk_main_back : assert property (
    req.rd && req.addr == 4'h0 |=> rdata == main_r) else $error("main control read back wrong");
  chk_mode_back : assert property (
    req.rd && req.addr == 4'h1 |=> rdata == mode_r) else $error("mode control read back wrong");
  chk_gate_low : assert property (
    calm_r == 2'h3 && !mode_r[4] |-> !compare_out) else $error("pin high while output disabled");
  chk_init_level : assert property (
    calm_r == 2'h3 && main_r[0] && mode_r[4] && mode_r[2:1] != 2'h3 |-> compare_out == mode_r[5])
    else $error("pin not at initial level");
  chk_irq_gate : assert property (
    !ie_r && !$past(ie_r) |-> !capture_irq) else $error("request while interrupt disabled");
  chk_irq_drop : assert property (
    wr_ie && !req.wdata[0] |=> ##1 !capture_irq) else $error("request outlived its enable");
  chk_sleep_hold : assert property (
    $rose(capture_irq) && $past(ie_r, 2) |-> !($past(sys.sleep_power_down) && $past(sys.sleep_power_down, 2)))
    else $error("flag raised in power-down");
  chk_run_idle : assert property (
    req.rd && req.addr == 4'h7 && calm_r == 2'h3 && !main_r[0] |=> rdata == 8'h00) else $error("running while off");
endmodule
bind ctm_timer ctm_timer_chk #(.CNT_W(CNT_W)) chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .sys(sys),
  .event_in(event_in), .rdata(rdata), .compare_out(compare_out), .capture_irq(capture_irq));

// *** tb/ctm_timer_tb_top.sv ***
// Self-checking bench: register map, count clocks, sleep, capture modes and output pin.
// Assumes the partner model supplies companion pulses and the event line.
`timescale 1ns/100ps
module ctm_timer_tb_top;
  import ctm_pkg::*;
  logic       clk_sys, rst_n, ev_cmd, pd, sb, halt, tick, restart, event_in, compare_out, capture_irq;
  logic [7:0] rdata;
  ctm_req_t   req;
  ctm_sys_t   sys;
  int         miscompares, n_tests;
  assign sys = '{pd, sb, halt, tick, restart};
  ctm_timer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .sys(sys), .event_in(event_in),
    .rdata(rdata), .compare_out(compare_out), .capture_irq(capture_irq));
  ctm_partner part_u (.clk_sys(clk_sys), .rst_n(rst_n), .ev_cmd(ev_cmd), .comp_tick(tick),
    .comp_restart(restart), .event_out(event_in));
  // Free-running 40 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  // Bus cycles hold the strobe exactly one cycle, as the port expects.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  task automatic rdv(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask
  task automatic ck(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rdv(a, v);
    cmp($sformatf("reg %h", a), {8'h00, e}, {8'h00, v});
  endtask
  task automatic ck16(input logic [3:0] a, input logic [15:0] e);
    logic [7:0] lo, hi;
    rdv(a, lo);
    rdv(a + 4'h1, hi);
    cmp($sformatf("reg %h", a), e, {hi, lo});
  endtask
  task automatic w16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  // Waits long enough for synchroniser and filter delay together.
  task automatic ev(input logic v);
    @(posedge clk_sys);
    ev_cmd <= v;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic s_regs;
    logic [3:0] wa [12] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd, 4'h2, 4'h3, 4'he, 4'hf};
    logic [7:0] wm [12] = '{8'h57, 8'h77, 8'h51, 8'h01, 8'h01, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 16; i++) ck(4'(i), 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(wa[i], 8'hff);
      ck(wa[i], wm[i]);
    end
    do_reset;
  endtask
  // Count advance over exactly twenty cycles between two reads.
  task automatic rate(input logic [7:0] main, input logic [1:0] s, input logic [7:0] e);
    logic [7:0] a, b;
    @(posedge clk_sys);
    pd <= s[1];
    sb <= s[0];
    wr(CTM_OFS_CTRL_MAIN, main);
    rdv(CTM_OFS_CNT_LO, a);
    repeat (18) @(posedge clk_sys);
    rdv(CTM_OFS_CNT_LO, b);
    cmp("count step", {8'h00, e}, {8'h00, b - a});
  endtask
  task automatic s_rate;
    wr(CTM_OFS_CTRL_MODE, 8'h00);
    w16(CTM_OFS_CCV_LO, 16'hffff);
    rate(8'h01, 2'h0, 8'h14);
    rate(8'h03, 2'h0, 8'h0a);
    rate(8'h05, 2'h0, 8'h05);
    rate(8'h07, 2'h0, 8'h00);
    rate(8'h00, 2'h0, 8'h00);
    rate(8'h01, 2'h1, 8'h00);
    rate(8'h41, 2'h1, 8'h14);
    rate(8'h41, 2'h2, 8'h00);
    rate(8'h41, 2'h0, 8'h14);
  endtask
  task automatic s_follow;
    for (int f = 1; f >= 0; f--) begin
      wr(CTM_OFS_CTRL_MAIN, f ? 8'h17 : 8'h07);
      wr(CTM_OFS_CNT_LO, 8'h55);
      repeat (40) @(posedge clk_sys);
      ck(CTM_OFS_CNT_LO, f ? 8'h00 : 8'h55);
    end
  endtask
  task automatic s_out;
    for (int i = 0; i < 4; i++) begin
      wr(CTM_OFS_CTRL_MODE, 8'(i << 4));
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp("compare pin", 16'(i == 3), 16'(compare_out));
    end
  endtask
  task automatic s_cap(input logic e);
    wr(CTM_OFS_INT_EN, 8'h01);
    wr(CTM_OFS_CTRL_MODE, 8'h02);
    wr(CTM_OFS_EVT_CTRL, {3'h0, e, 4'h1});
    ev(e);
    w16(CTM_OFS_CNT_LO, 16'h1234 + 16'(e));
    wr(CTM_OFS_INT_FLAG, 8'h01);
    ev(!e);
    cmp("capture irq", 16'h0001, 16'(capture_irq));
    ck(CTM_OFS_INT_FLAG, 8'h01);
    w16(CTM_OFS_CNT_LO, 16'h5678);
    ev(e);
    ck16(CTM_OFS_CCV_LO, 16'h1234 + 16'(e));
    ck(CTM_OFS_INT_FLAG, 8'h00);
  endtask
  task automatic s_meas;
    wr(CTM_OFS_EVT_CTRL, 8'h01);
    wr(CTM_OFS_CTRL_MODE, 8'h03);
    ev(0);
    w16(CTM_OFS_CNT_LO, 16'h0abc);
    wr(CTM_OFS_INT_FLAG, 8'h01);
    ev(1);
    ck(CTM_OFS_INT_FLAG, 8'h01);
    ck(CTM_OFS_CNT_LO, 8'h00);
    ck16(CTM_OFS_CCV_LO, 16'h0abc);
    ev(0);
    ck(CTM_OFS_INT_FLAG, 8'h00);
    wr(CTM_OFS_CTRL_MODE, 8'h04);
    w16(CTM_OFS_CNT_LO, 16'h0abc);
    ev(1);
    ck(CTM_OFS_CNT_LO, 8'h00);
    ck(CTM_OFS_INT_FLAG, 8'h00);
    w16(CTM_OFS_CNT_LO, 16'h0def);
    ev(0);
    ck(CTM_OFS_INT_FLAG, 8'h01);
    ck16(CTM_OFS_CCV_LO, 16'h0def);
    wr(CTM_OFS_CTRL_MODE, 8'h05);
    ev(1);
    ck(CTM_OFS_CNT_LO, 8'h00);
    w16(CTM_OFS_CNT_LO, 16'h0123);
    ev(0);
    ck(CTM_OFS_INT_FLAG, 8'h00);
    ck16(CTM_OFS_CCV_LO, 16'h0123);
    ev(1);
    ck(CTM_OFS_INT_FLAG, 8'h01);
    ev(0);
  endtask
  task automatic s_ignore;
    for (int m = 0; m < 2; m++) begin
      wr(CTM_OFS_CTRL_MODE, m ? 8'h07 : 8'h00);
      w16(CTM_OFS_CCV_LO, 16'h4321);
      ev(1);
      ev(0);
      ck16(CTM_OFS_CCV_LO, 16'h4321);
    end
  endtask
  // A three-cycle blip must be rejected only while the filter is on; a stable level still passes it.
  task automatic s_filter;
    wr(CTM_OFS_CTRL_MODE, 8'h02);
    w16(CTM_OFS_CNT_LO, 16'h0aaa);
    for (int f = 1; f >= 0; f--) begin
      wr(CTM_OFS_EVT_CTRL, f ? 8'h41 : 8'h01);
      w16(CTM_OFS_CCV_LO, 16'h0000);
      @(posedge clk_sys);
      ev_cmd <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ev(0);
      ck16(CTM_OFS_CCV_LO, f ? 16'h0000 : 16'h0aaa);
    end
    wr(CTM_OFS_EVT_CTRL, 8'h41);
    w16(CTM_OFS_CCV_LO, 16'h0000);
    ev(1);
    ev(0);
    ck16(CTM_OFS_CCV_LO, 16'h0aaa);
  endtask
  task automatic s_shot;
    wr(CTM_OFS_CTRL_MAIN, 8'h00);
    wr(CTM_OFS_CTRL_MODE, 8'h16);
    w16(CTM_OFS_CCV_LO, 16'h0030);
    w16(CTM_OFS_CNT_LO, 16'h0030);
    wr(CTM_OFS_CTRL_MAIN, 8'h01);
    for (int e = 0; e < 2; e++) begin
      wr(CTM_OFS_EVT_CTRL, {3'h0, 1'(e), 4'h1});
      wr(CTM_OFS_INT_FLAG, 8'h01);
      ev(1);
      cmp("shot pin", 16'h0001, 16'(compare_out));
      repeat (60) @(posedge clk_sys);
      wr(CTM_OFS_INT_FLAG, 8'h01);
      ev(0);
      repeat (60) @(posedge clk_sys);
      ck(CTM_OFS_INT_FLAG, 8'(e));
    end
    wr(CTM_OFS_INT_EN, 8'h00);
  endtask
  // Timeout mode: the run bit follows the start and stop edges, which swap with the edge bit.
  task automatic s_tout;
    wr(CTM_OFS_CTRL_MODE, 8'h01);
    w16(CTM_OFS_CCV_LO, 16'hffff);
    for (int e = 0; e < 2; e++) begin
      wr(CTM_OFS_EVT_CTRL, {3'h0, 1'(e), 4'h1});
      ev(1);
      ck(CTM_OFS_RUN_STATE, 8'(e == 0));
      ev(0);
      ck(CTM_OFS_RUN_STATE, 8'(e));
    end
  endtask
  // With a clock that never ticks, only the early-rise setting can lift the pin.
  task automatic s_early;
    wr(CTM_OFS_EVT_CTRL, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(CTM_OFS_CTRL_MAIN, 8'h00);
      wr(CTM_OFS_CTRL_MODE, k ? 8'h56 : 8'h16);
      wr(CTM_OFS_CTRL_MAIN, 8'h07);
      ev(1);
      cmp("shot start pin", 16'(k), 16'(compare_out));
      ev(0);
    end
  endtask
  // Hang guard, sized well past the full sequence.
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_sim;
  end
  initial begin
    req = '0;
    {rst_n, ev_cmd, pd, sb, halt} = 5'h00;
    miscompares = 0;
    n_tests = 0;
    do_reset;
    s_regs;
    s_rate;
    s_follow;
    s_out;
    s_cap(1'b0);
    s_cap(1'b1);
    s_meas;
    s_ignore;
    s_filter;
    s_shot;
    s_tout;
    s_early;
    end_sim;
  end
endmodule
